// >>> rtl/meter_mode_display_control.sv
// Mode select, conversion sequencing and display control of the meter.
// Assumes mclk_in is the oscillator and pins arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Measure select high chooses frequency counting
// - Probe select forces probe mode, overload text; measure high still counts
// - Probe low: measure select alone picks mode
// - Count gate is oscillator over 40000
// - Range pin high shortens integration tenfold
// - Point inputs place the decimal point
// - Point pull-downs only outside probe mode
// - Probe pins drive annunciators, low also buzzes
// - Beeper request sounds buzzer in any mode
// - Done pin low exactly ten oscillator cycles
// - Done pulse loads the display latch
// - Pin held high freezes display only
// - Overrange above 3999 counts
// - Underrange at 380 counts or below
// - Counters run at oscillator over two
// - Buzzer over eight, backplane over 240
// - Probe holds auto-zero; counting keeps points
// - Integration 2000 counts, or 200 ranged
// - Frequency auto-ranges four decades with point
module meter_mode_display_control
  import meter_pkg::*;
#(
  parameter int GATE_CYCLES = GATE_DIV
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic measure_select_in,
  input wire logic logic_probe_in,
  input wire logic range_or_count_pin_in,
  input wire logic point_sel0_low_probe_in,
  input wire logic point_sel1_high_probe_in,
  input wire logic beeper_request_in,
  input wire logic integ_positive_in,
  input wire logic eoc_hold_in,
  output logic eoc_hold_out,
  output logic eoc_hold_oe_out,
  output logic [DIG_W-1:0] display_value_out,
  output logic [1:0] point_out,
  output logic over_range_out,
  output logic below_range_flag_out,
  output logic overload_text_out,
  output logic high_annunc_out,
  output logic low_annunc_out,
  output logic buzzer_out,
  output logic backplane_out,
  output logic pulldown_en_out,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);
  pin_in_s pin_raw;
  pin_in_s pin_s;
  conv_state_e state_q;
  logic [DIG_W-1:0] cnt_q;
  logic [3:0] eoc_cnt_q;
  logic [DIG_W-1:0] result_q;
  logic [1:0] res_dp_q;
  logic res_over_q;
  logic [1:0] disp_dp_q;
  logic [FREQ_W-1:0] fcnt_q;
  logic [FREQ_W-1:0] fsnap_q;
  logic range_d1_q;
  logic count_tick, tone, backplane, gate_tick, soft_hold_q;
  logic load_ok, eoc_last, buzz_on, wb_req;
  logic [DIG_W-1:0] int_len;
  logic [DIG_W+1:0] franged;

  assign pin_raw = {measure_select_in, logic_probe_in, range_or_count_pin_in,
                    point_sel1_high_probe_in, point_sel0_low_probe_in,
                    beeper_request_in, integ_positive_in, eoc_hold_in};

  meter_sync #(
    .W($bits(pin_in_s))
  ) u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .raw_in(pin_raw),
    .sync_out(pin_s)
  );

  meter_timebase #(
    .GATE_CYCLES(GATE_CYCLES)
  ) u_tb (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .count_tick_out(count_tick),
    .tone_out(tone),
    .backplane_out(backplane),
    .gate_tick_out(gate_tick)
  );

  // Decade select of a gate count
  function automatic logic [DIG_W+1:0] freq_range(
    input logic [FREQ_W-1:0] f
  );
    logic [FREQ_W-1:0] v;
    logic [1:0] d;
    v = f;
    d = DP_THREE;
    if (f >= FREQ_W'(FREQ_DEC3)) begin
      v = f / FREQ_W'(1000);
      d = DP_NONE;
    end else if (f >= FREQ_W'(FREQ_DEC2)) begin
      v = f / FREQ_W'(100);
      d = DP_ONE;
    end else if (f >= FREQ_W'(FREQ_DEC1)) begin
      v = f / FREQ_W'(10);
      d = DP_TWO;
    end
    if (v > FREQ_W'(FULL_SCALE))
      v = FREQ_W'(FULL_SCALE);
    return {d, v[DIG_W-1:0]};
  endfunction : freq_range

  // Auto-ranged count of the closing gate
  assign franged = freq_range(fcnt_q);
  assign int_len = pin_s.range ? DIG_W'(INT_COUNTS / RANGE_FACTOR)
                               : DIG_W'(INT_COUNTS);
  assign eoc_last = (state_q == ST_EOC) &&
                    (eoc_cnt_q == 4'(EOC_CYCLES - 1));
  // Pin high while driven low means hold
  assign load_ok = eoc_last && !pin_s.hold && !soft_hold_q;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      range_d1_q <= 1'b0;
      fcnt_q <= '0;
      fsnap_q <= '0;
    end else if (ce_in) begin
      range_d1_q <= pin_s.range;
      if (gate_tick) begin
        fsnap_q <= fcnt_q;
        fcnt_q <= (pin_s.range && !range_d1_q) ? FREQ_W'(1) : '0;
      end else if (pin_s.range && !range_d1_q && !(&fcnt_q)) begin
        fcnt_q <= fcnt_q + FREQ_W'(1);
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_AZ;
      cnt_q <= '0;
      eoc_cnt_q <= '0;
      result_q <= '0;
      res_dp_q <= DP_NONE;
      res_over_q <= 1'b0;
      eoc_hold_out <= 1'b1;
    end else if (ce_in) begin
      unique case (state_q)
        ST_AZ: begin
          if (pin_s.measure) begin
            state_q <= ST_GATE;
          end else if (!pin_s.probe && count_tick) begin
            if (cnt_q == DIG_W'(AZ_COUNTS - 1)) begin
              state_q <= ST_INT;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + DIG_W'(1);
            end
          end
        end
        ST_INT: begin
          if (pin_s.measure || pin_s.probe) begin
            state_q <= ST_AZ;
            cnt_q <= '0;
          end else if (count_tick) begin
            if (cnt_q >= int_len - DIG_W'(1)) begin
              state_q <= ST_DEINT;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + DIG_W'(1);
            end
          end
        end
        ST_DEINT: begin
          if (pin_s.measure || pin_s.probe) begin
            state_q <= ST_AZ;
            cnt_q <= '0;
          end else if (count_tick) begin
            if (!pin_s.integ_pos || cnt_q == DIG_W'(DEINT_MAX)) begin
              res_over_q <= (cnt_q > DIG_W'(FULL_SCALE));
              result_q <= (cnt_q > DIG_W'(FULL_SCALE))
                          ? DIG_W'(FULL_SCALE) : cnt_q;
              res_dp_q <= DP_NONE;
              state_q <= ST_EOC;
              eoc_cnt_q <= '0;
              eoc_hold_out <= 1'b0;
            end else begin
              cnt_q <= cnt_q + DIG_W'(1);
            end
          end
        end
        ST_GATE: begin
          if (!pin_s.measure) begin
            state_q <= ST_AZ;
            cnt_q <= '0;
          end else if (gate_tick) begin
            result_q <= franged[DIG_W-1:0];
            res_dp_q <= franged[DIG_W+1:DIG_W];
            res_over_q <= (fcnt_q >= FREQ_W'(FREQ_DEC4));
            state_q <= ST_EOC;
            eoc_cnt_q <= '0;
            eoc_hold_out <= 1'b0;
          end
        end
        ST_EOC: begin
          eoc_cnt_q <= eoc_cnt_q + 4'h1;
          if (eoc_last) begin
            eoc_hold_out <= 1'b1;
            cnt_q <= '0;
            state_q <= pin_s.measure ? ST_GATE : ST_AZ;
          end
        end
        default: begin
          state_q <= ST_AZ;
          cnt_q <= '0;
          eoc_hold_out <= 1'b1;
        end
      endcase
    end
  end

  // Display latch loads at pulse end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      display_value_out <= '0;
      disp_dp_q <= DP_NONE;
      over_range_out <= 1'b0;
    end else if (ce_in && load_ok) begin
      display_value_out <= result_q;
      disp_dp_q <= res_dp_q;
      over_range_out <= res_over_q;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) below_range_flag_out <= 1'b0;
    else if (ce_in)
      below_range_flag_out <= (display_value_out <= DIG_W'(UNDER_LIMIT));
  end

  // Point, annunciators and pull-downs
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      point_out <= DP_NONE;
      overload_text_out <= 1'b0;
      high_annunc_out <= 1'b0;
      low_annunc_out <= 1'b0;
      pulldown_en_out <= 1'b1;
      eoc_hold_oe_out <= 1'b0;
    end else if (ce_in) begin
      eoc_hold_oe_out <= 1'b1;
      overload_text_out <= pin_s.probe;
      if (pin_s.probe && !pin_s.measure)
        point_out <= DP_NONE;
      else if (pin_s.measure)
        point_out <= disp_dp_q;
      else
        point_out <= {pin_s.dp1, pin_s.dp0};
      high_annunc_out <= pin_s.probe && pin_s.dp1;
      low_annunc_out <= pin_s.probe && pin_s.dp0;
      pulldown_en_out <= !pin_s.probe;
    end
  end

  assign buzz_on = pin_s.beep || (pin_s.probe && pin_s.dp0);
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      buzzer_out <= 1'b0;
      backplane_out <= 1'b0;
    end else if (ce_in) begin
      buzzer_out <= buzz_on && tone;
      backplane_out <= backplane;
    end
  end

  // Wishbone classic slave, one wait state
  assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
      soft_hold_q <= CTRL_HOLD_RST;
    end else if (ce_in) begin
      wb_ack_out <= wb_req;
      if (wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in &&
          wb_adr_in == ADR_CTRL && wb_sel_in[0])
        soft_hold_q <= wb_dat_in[CTRL_HOLD_BIT];
      if (wb_req && !wb_we_in) begin
        unique case (wb_adr_in)
          ADR_CTRL: wb_dat_out <= {31'h0, soft_hold_q};
          ADR_STAT: wb_dat_out <= {22'h0, state_q, pin_s.measure,
                                   pin_s.probe, over_range_out,
                                   below_range_flag_out, eoc_hold_out,
                                   pin_s.hold, buzz_on};
          ADR_RESULT: wb_dat_out <= {18'h0, point_out, display_value_out};
          ADR_RAW: wb_dat_out <= {9'h0, fsnap_q};
          default: wb_dat_out <= '0;
        endcase
      end
    end
  end
endmodule : meter_mode_display_control
`default_nettype wire

// >>> rtl/meter_pkg.sv
// Constants, states and pin bundle of the meter mode and display control.
// Assumes a single oscillator clock; all dividers count its cycles.
package meter_pkg;

  // Divider ratios of the time base
  localparam int CNT_DIV = 2;
  localparam int BUZ_DIV = 8;
  localparam int BP_DIV = 240;
  localparam int GATE_DIV = 40000;

  // Conversion timing in counter counts, done pulse in oscillator cycles
  localparam int AZ_COUNTS = 1000;
  localparam int INT_COUNTS = 2000;
  localparam int RANGE_FACTOR = 10;
  localparam int DEINT_MAX = 4000;
  localparam int EOC_CYCLES = 10;

  // Reading limits
  localparam int FULL_SCALE = 3999;
  localparam int UNDER_LIMIT = 380;
  localparam int DIG_W = 12;
  localparam int FREQ_W = 23;
  localparam int FREQ_DEC1 = 4000;
  localparam int FREQ_DEC2 = 40000;
  localparam int FREQ_DEC3 = 400000;
  localparam int FREQ_DEC4 = 4000000;

  // Point codes
  localparam logic [1:0] DP_NONE = 2'h0;
  localparam logic [1:0] DP_ONE = 2'h1;
  localparam logic [1:0] DP_TWO = 2'h2;
  localparam logic [1:0] DP_THREE = 2'h3;

  // Register map
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_RESULT = 8'h08;
  localparam logic [7:0] ADR_RAW = 8'h0c;
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic CTRL_HOLD_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_AZ = 3'b000,
    ST_INT = 3'b001,
    ST_DEINT = 3'b010,
    ST_GATE = 3'b011,
    ST_EOC = 3'b100
  } conv_state_e;

  typedef struct packed {
    logic measure;
    logic probe;
    logic range;
    logic dp1;
    logic dp0;
    logic beep;
    logic integ_pos;
    logic hold;
  } pin_in_s;

endpackage : meter_pkg

// >>> rtl/meter_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are slow levels; bits are not kept coherent.
`timescale 1ns/100ps
`default_nettype none
module meter_sync #(
  parameter int W = 8
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      meta_q <= raw_in;
      sync_out <= meta_q;
    end
  end
endmodule : meter_sync
`default_nettype wire

// >>> rtl/meter_timebase.sv
// Time base: counter tick, buzzer tone, backplane and counter gate.
// Assumes the clock is the oscillator; ce_in freezes every divider.
`timescale 1ns/100ps
`default_nettype none
module meter_timebase
  import meter_pkg::*;
#(
  parameter int GATE_CYCLES = GATE_DIV
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  output logic count_tick_out,
  output logic tone_out,
  output logic backplane_out,
  output logic gate_tick_out
);
  localparam int GW = $clog2(GATE_CYCLES + 1);
  localparam int BW = $clog2(BP_DIV);
  localparam int TW = $clog2(BUZ_DIV);
  logic [GW-1:0] gate_q;
  logic [BW-1:0] bp_q;
  logic [TW-1:0] tone_q;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) count_tick_out <= 1'b0;
    else if (ce_in) count_tick_out <= ~count_tick_out;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tone_q <= '0;
      bp_q <= '0;
      backplane_out <= 1'b0;
    end else if (ce_in) begin
      tone_q <= tone_q + TW'(1);
      if (bp_q == BW'(BP_DIV / 2 - 1) || bp_q == BW'(BP_DIV - 1))
        backplane_out <= ~backplane_out;
      bp_q <= (bp_q == BW'(BP_DIV - 1)) ? '0 : bp_q + BW'(1);
    end
  end
  assign tone_out = tone_q[TW-1];

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_q <= '0;
      gate_tick_out <= 1'b0;
    end else if (ce_in) begin
      gate_tick_out <= (gate_q == GW'(GATE_CYCLES - 2));
      gate_q <= (gate_q == GW'(GATE_CYCLES - 1)) ? '0 : gate_q + GW'(1);
    end
  end
endmodule : meter_timebase
`default_nettype wire

// >>> sim/meter_panel.sv
// Far-side model: count source, range level, hold switch, range pulse.
// Assumes the bench sets panel levels at clock edges.
`timescale 1ns/100ps
`default_nettype none
module meter_panel (
  input wire logic mclk_in,
  input wire logic [7:0] period_in,
  input wire logic range_lvl_in,
  input wire logic ext_hold_in,
  input wire logic eoc_hold_out_in,
  input wire logic eoc_hold_oe_in,
  input wire logic over_in,
  input wire logic under_in,
  output logic range_pin_out,
  output logic eoc_pin_out,
  output logic range_pulse_out
);
  logic [7:0] ph_q = 8'h00;
  logic last_q = 1'b1;
  // Square count source, one rise per period
  always_ff @(posedge mclk_in) begin
    ph_q <= (ph_q + 8'h01 >= period_in) ? 8'h00 : ph_q + 8'h01;
    last_q <= eoc_pin_out;
  end
  assign range_pin_out = (period_in == 8'h00) ? range_lvl_in :
                         (ph_q < period_in / 2);
  assign eoc_pin_out = ext_hold_in |
                       (eoc_hold_oe_in ? eoc_hold_out_in : ~last_q);
  assign range_pulse_out = (over_in | under_in) & ~eoc_pin_out;
endmodule : meter_panel
`default_nettype wire

// >>> sim/meter_mode_display_control_asserts.sv
// Checker of the meter control outputs.
// Assumes ce_in stays high.
`timescale 1ns/100ps
`default_nettype none
module meter_checker
  import meter_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic eoc_hold_out,
  input wire logic [DIG_W-1:0] display_value_out,
  input wire logic below_range_flag_out,
  input wire logic overload_text_out,
  input wire logic high_annunc_out,
  input wire logic low_annunc_out,
  input wire logic backplane_out,
  input wire logic pulldown_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic bp_last_q;
  logic bp_seen_q;
  logic [7:0] bp_cnt_q;
  // Cycles since last backplane edge
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bp_last_q <= 1'b0;
      bp_seen_q <= 1'b0;
      bp_cnt_q <= 8'h00;
    end else begin
      bp_last_q <= backplane_out;
      bp_seen_q <= bp_seen_q | (backplane_out != bp_last_q);
      bp_cnt_q <= (backplane_out != bp_last_q) ? 8'h00 : bp_cnt_q + 8'h01;
    end
  end
  chk_done_width: assert property ($fell(eoc_hold_out) |->
    ##1 !eoc_hold_out[*8] ##1 !eoc_hold_out ##1 eoc_hold_out)
    else $error("done pulse width wrong");
  chk_load_done: assert property (!$stable(display_value_out) |->
    !$past(eoc_hold_out)) else $error("display changed outside done");
  chk_under_flag: assert property ($past(nrst_in) |->
    below_range_flag_out == ($past(display_value_out) <= UNDER_LIMIT))
    else $error("underrange flag wrong");
  chk_display_clamp: assert property (
    display_value_out <= FULL_SCALE) else $error("display above full scale");
  chk_bp_period: assert property (
    (backplane_out != bp_last_q) && bp_seen_q |-> bp_cnt_q == 8'h77)
    else $error("backplane half period wrong");
  chk_bp_alive: assert property (bp_seen_q |-> bp_cnt_q <= 8'h77)
    else $error("backplane stalled");
  chk_pull_probe: assert property (
    overload_text_out == !pulldown_en_out) else $error("pulldown wrong");
  chk_annunc_probe: assert property (
    high_annunc_out || low_annunc_out |-> overload_text_out)
    else $error("annunciator outside probe");
  chk_wb_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("bus ack late");
  chk_wb_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("bus ack too long");
endmodule : meter_checker
bind meter_mode_display_control meter_checker chk_i (.mclk_in, .nrst_in,
  .wb_cyc_in, .wb_stb_in, .wb_ack_out, .eoc_hold_out, .display_value_out,
  .below_range_flag_out, .overload_text_out, .high_annunc_out,
  .low_annunc_out, .backplane_out, .pulldown_en_out);
`default_nettype wire

// >>> sim/tb.sv
// Bench of the meter control: pins, bus, conversion and count timing.
// Assumes a shortened count gate and the panel model on the far side.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin \
  err_count++; $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module tb;
  import meter_pkg::*;
  localparam int GATE = 200;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic meas = 1'b0, probe = 1'b0, rlvl = 1'b0, beep = 1'b0, integ = 1'b0;
  logic hold = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [1:0] dp = 2'h0;
  logic [3:0] sel = 4'hf;
  logic [7:0] period = 8'h00, adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, rdat, rnd = 32'h5fe48fef;
  logic eoc_o, eoc_oe, over, under, txt, hi, lo, buz, bp, pd, ack;
  logic rpin, epin, rpulse;
  logic [DIG_W-1:0] disp;
  logic [1:0] pt;
  int err_count = 0, num_checks = 0, n, p1, p2;
  meter_mode_display_control #(.GATE_CYCLES(GATE)) uut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .measure_select_in(meas), .logic_probe_in(probe),
    .range_or_count_pin_in(rpin), .point_sel0_low_probe_in(dp[0]),
    .point_sel1_high_probe_in(dp[1]), .beeper_request_in(beep),
    .integ_positive_in(integ), .eoc_hold_in(epin), .eoc_hold_out(eoc_o),
    .eoc_hold_oe_out(eoc_oe), .display_value_out(disp), .point_out(pt),
    .over_range_out(over), .below_range_flag_out(under),
    .overload_text_out(txt), .high_annunc_out(hi), .low_annunc_out(lo),
    .buzzer_out(buz), .backplane_out(bp), .pulldown_en_out(pd),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));
  meter_panel panel (.mclk_in(mclk_in), .period_in(period),
    .range_lvl_in(rlvl), .ext_hold_in(hold), .eoc_hold_out_in(eoc_o),
    .eoc_hold_oe_in(eoc_oe), .over_in(over), .under_in(under),
    .range_pin_out(rpin), .eoc_pin_out(epin), .range_pulse_out(rpulse));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [1:0] exp_point(input logic p, input logic [1:0] d);
    return p ? DP_NONE : d;
  endfunction : exp_point
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge mclk_in);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_in);
  endtask : wb
  task automatic rises(input int c, output int r);
    logic last;
    last = buz;
    r = 0;
    repeat (c) begin
      @(posedge mclk_in);
      if (buz === 1'b1 && last === 1'b0) r++;
      last = buz;
    end
  endtask : rises
  task automatic wait_eoc(input int lim, output int k);
    k = 0;
    while (eoc_o !== 1'b1 && k < lim) begin
      @(posedge mclk_in);
      k++;
    end
    while (eoc_o !== 1'b0 && k < lim) begin
      @(posedge mclk_in);
      k++;
    end
    `CHK("eoc_wait", 1'b1, k < lim)
  endtask : wait_eoc
  task automatic finish_test;
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (90000) @(posedge mclk_in);
    err_count++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    `CHK("eoc_rst", 1'b1, eoc_o)
    `CHK("pd_rst", 1'b1, pd)
    `CHK("oe_rst", 1'b0, eoc_oe)
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    wb(1'b1, ADR_CTRL, 32'h1, 4'he);
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf);
    `CHK("ctrl_sel", 1'b0, rd[CTRL_HOLD_BIT])
    `CHK("oe", 1'b1, eoc_oe)
    wb(1'b1, ADR_CTRL, 32'h1, 4'hf);
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf);
    `CHK("ctrl", 1'b1, rd[CTRL_HOLD_BIT])
    wb(1'b1, ADR_CTRL, 32'h0, 4'hf);
    wb(1'b0, 8'h10, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, rd)
    probe <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      dp <= rnd[1:0];
      repeat (5) @(posedge mclk_in);
      `CHK("text", 1'b1, txt)
      `CHK("pulldown", 1'b0, pd)
      `CHK("point_probe", exp_point(1'b1, dp), pt)
      `CHK("high", dp[1], hi)
      `CHK("low", dp[0], lo)
      rises(16, n);
      `CHK("buzz", dp[0] ? 2 : 0, n)
    end
    n = 0;
    repeat (8000) begin
      @(posedge mclk_in);
      if (eoc_o !== 1'b1) n++;
    end
    `CHK("az_hold", 0, n)
    wb(1'b0, ADR_STAT, 32'h0, 4'hf);
    `CHK("az_state", ST_AZ, rd[9:7])
    probe <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      dp <= d[1:0];
      repeat (5) @(posedge mclk_in);
      `CHK("point", exp_point(1'b0, dp), pt)
      `CHK("text_off", 1'b0, txt)
    end
    beep <= 1'b1;
    repeat (4) @(posedge mclk_in);
    rises(80, n);
    `CHK("beep", 10, n)
    beep <= 1'b0;
    wait_eoc(20000, n);
    wait_eoc(20000, p1);
    rlvl <= 1'b1;
    wait_eoc(20000, n);
    wait_eoc(20000, p2);
    n = (INT_COUNTS - INT_COUNTS / RANGE_FACTOR) * CNT_DIV;
    `CHK("range", n, p1 - p2)
    `CHK("under", 1'b1, under)
    `CHK("not_over", 1'b0, over)
    integ <= 1'b1;
    wait_eoc(30000, n);
    `CHK("pulse", 1'b1, rpulse)
    repeat (12) @(posedge mclk_in);
    `CHK("over", 1'b1, over)
    `CHK("clamp", 12'(FULL_SCALE), disp)
    hold <= 1'b1;
    integ <= 1'b0;
    repeat (2) wait_eoc(30000, n);
    repeat (12) @(posedge mclk_in);
    `CHK("frozen", 12'(FULL_SCALE), disp)
    hold <= 1'b0;
    wait_eoc(30000, n);
    repeat (12) @(posedge mclk_in);
    `CHK("loaded", 1'b1, under)
    `CHK("loaded_val", 12'h0, disp)
    meas <= 1'b1;
    period <= 8'h08;
    repeat (3) wait_eoc(1000, n);
    repeat (12) @(posedge mclk_in);
    `CHK("count", 12'(GATE / 8), disp)
    `CHK("point_cnt", DP_THREE, pt)
    wb(1'b0, ADR_RAW, 32'h0, 4'hf);
    `CHK("raw", 23'(GATE / 8), rd[22:0])
    wb(1'b0, ADR_RESULT, 32'h0, 4'hf);
    `CHK("result_val", 12'(GATE / 8), rd[11:0])
    `CHK("result_pt", DP_THREE, rd[13:12])
    probe <= 1'b1;
    repeat (2) wait_eoc(1000, n);
    `CHK("gate", GATE, n)
    `CHK("point_vis", DP_THREE, pt)
    finish_test;
  end
endmodule : tb
`default_nettype wire
